/* File: design/xpc_pkg.sv */
// shared constants, commands and types of the crosspoint configuration host
package xpc_pkg;
  // device geometry
  localparam int XPC_ROWS = 17;
  localparam int XPC_SEL_W = 5;
  localparam int XPC_WORD_W = 7;
  localparam int XPC_INSEL_W = 6;
  localparam int XPC_EN_BIT = 6;
  localparam logic [4:0] XPC_SEL_LAST = 5'h10;
  localparam logic [4:0] XPC_SEL_BCAST = 5'h11;
  // register byte offsets on the avalon slave
  localparam logic [3:0] XPC_OFS_CMD = 4'h0;
  localparam logic [3:0] XPC_OFS_SEL = 4'h4;
  localparam logic [3:0] XPC_OFS_WORD = 4'h8;
  localparam logic [3:0] XPC_OFS_STAT = 4'hc;
  // command codes written to the command register, bits 2:0
  localparam logic [2:0] XPC_CMD_WRITE = 3'h1;
  localparam logic [2:0] XPC_CMD_UPDATE = 3'h2;
  localparam logic [2:0] XPC_CMD_READ = 3'h3;
  localparam logic [2:0] XPC_CMD_RESET = 3'h4;
  // status register bit positions
  localparam int XPC_ST_BUSY = 0;
  localparam int XPC_ST_RST_DONE = 1;
  localparam int XPC_ST_ALL_ROWS = 2;
  localparam int XPC_ST_BAD_SEL = 3;
  localparam int XPC_ST_RB_VALID = 4;
  localparam int XPC_ST_RB_LSB = 8;
  // reset values of the software registers
  localparam logic [4:0] XPC_SEL_RST = 5'h00;
  localparam logic [6:0] XPC_WORD_RST = 7'h00;
  // pin timing in ns, converted to whole clock cycles (least times round up)
  localparam int XPC_CLK_NS = 100;
  localparam int XPC_T_DSW_NS = 15;
  localparam int XPC_T_CSU_NS = 0;
  localparam int XPC_T_WP_NS = 15;
  localparam int XPC_T_UW_NS = 15;
  localparam int XPC_T_TW_NS = 15;
  localparam int XPC_T_RDE_NS = 30;
  localparam int XPC_T_WHU_NS = 10;

  function automatic logic [3:0] xpc_min_cyc(input int ns);
    int c;
    c = (ns + XPC_CLK_NS - 1) / XPC_CLK_NS;
    return (c < 1) ? 4'h1 : 4'(c);
  endfunction : xpc_min_cyc

  localparam logic [3:0] XPC_DSW_CYC = xpc_min_cyc(XPC_T_DSW_NS);
  localparam logic [3:0] XPC_CSU_CYC = xpc_min_cyc(XPC_T_CSU_NS);
  localparam logic [3:0] XPC_WP_CYC = xpc_min_cyc(XPC_T_WP_NS);
  localparam logic [3:0] XPC_UW_CYC = xpc_min_cyc(XPC_T_UW_NS);
  localparam logic [3:0] XPC_TW_CYC = xpc_min_cyc(XPC_T_TW_NS);
  localparam logic [3:0] XPC_RDE_CYC = xpc_min_cyc(XPC_T_RDE_NS);
  localparam logic [3:0] XPC_HOLD_CYC = xpc_min_cyc(XPC_T_WHU_NS);

  typedef enum logic [1:0] {XPC_OP_WRITE, XPC_OP_UPDATE, XPC_OP_READ, XPC_OP_RESET} xpc_op_t;
  typedef enum logic [1:0] {XPC_S_IDLE, XPC_S_SETUP, XPC_S_STROBE, XPC_S_HOLD} xpc_seq_st_t;
endpackage : xpc_pkg

/* File: design/xpc_seq_if.sv */
// request and answer between the register front end and the pin sequencer
`timescale 1ns/1ps
`default_nettype none
interface xpc_seq_if import xpc_pkg::*; ();
  logic req;
  xpc_op_t op;
  logic [4:0] sel;
  logic [6:0] word;
  logic done;
  logic [6:0] rdata;
  modport ctl (output req, output op, output sel, output word, input done, input rdata);
  modport seq (input req, input op, input sel, input word, output done, output rdata);
endinterface : xpc_seq_if
`default_nettype wire

/* File: design/xpc_pin_seq.sv */
// pin sequencer: turns one operation into a timed strobe cycle on the device pins
`timescale 1ns/1ps
`default_nettype none
module xpc_pin_seq import xpc_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  xpc_seq_if.seq sq,
  output logic cs_n,
  output logic we_n,
  output logic re_n,
  output logic update_n,
  output logic reset_n,
  output logic [4:0] sel,
  output logic [6:0] d_out,
  output logic [6:0] d_oe,
  input wire logic [6:0] d_in
);
  typedef struct packed {
    xpc_seq_st_t st;
    xpc_op_t op;
    logic [3:0] cnt;
    logic cs_n;
    logic we_n;
    logic re_n;
    logic upd_n;
    logic rst_n;
    logic [4:0] sel;
    logic [6:0] dout;
    logic [6:0] doe;
    logic [6:0] rdata;
    logic done;
  } xpc_seq_state_t;

  localparam xpc_seq_state_t XPC_SEQ_RST = '{st: XPC_S_IDLE, op: XPC_OP_WRITE, cnt: 4'h0,
    cs_n: 1'b1, we_n: 1'b1, re_n: 1'b1, upd_n: 1'b1, rst_n: 1'b1, sel: XPC_SEL_RST,
    dout: XPC_WORD_RST, doe: 7'h00, rdata: XPC_WORD_RST, done: 1'b0};

  xpc_seq_state_t q_ff;
  xpc_seq_state_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    case (q_ff.st)
      XPC_S_IDLE: begin
        if (sq.req) begin
          nxt_q.op = sq.op;
          nxt_q.sel = sq.sel;
          nxt_q.dout = sq.word;
          if (sq.op == XPC_OP_RESET) begin
            // reset acts without chip select
            nxt_q.rst_n = 1'b0;
            nxt_q.cnt = XPC_TW_CYC;
            nxt_q.st = XPC_S_STROBE;
          end else begin
            nxt_q.cs_n = 1'b0;
            // only a write drives the data lines; readback leaves them released
            nxt_q.doe = (sq.op == XPC_OP_WRITE) ? 7'h7f : 7'h00;
            nxt_q.cnt = (sq.op == XPC_OP_WRITE) ? XPC_DSW_CYC : XPC_CSU_CYC;
            nxt_q.st = XPC_S_SETUP;
          end
        end
      end
      XPC_S_SETUP: begin
        if (q_ff.cnt > 4'h1) begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end else begin
          nxt_q.st = XPC_S_STROBE;
          case (q_ff.op)
            XPC_OP_WRITE: begin
              nxt_q.we_n = 1'b0;
              nxt_q.cnt = XPC_WP_CYC;
            end
            XPC_OP_UPDATE: begin
              nxt_q.upd_n = 1'b0;
              nxt_q.cnt = XPC_UW_CYC;
            end
            default: begin
              nxt_q.re_n = 1'b0;
              nxt_q.cnt = XPC_RDE_CYC;
            end
          endcase
        end
      end
      XPC_S_STROBE: begin
        if (q_ff.cnt > 4'h1) begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end else begin
          if (q_ff.op == XPC_OP_READ) begin
            nxt_q.rdata = d_in;
          end
          // every strobe returns high so the transparent latch stops following
          nxt_q.we_n = 1'b1;
          nxt_q.upd_n = 1'b1;
          nxt_q.re_n = 1'b1;
          nxt_q.rst_n = 1'b1;
          nxt_q.cnt = XPC_HOLD_CYC;
          nxt_q.st = XPC_S_HOLD;
        end
      end
      default: begin
        if (q_ff.cnt > 4'h1) begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end else begin
          nxt_q.cs_n = 1'b1;
          nxt_q.doe = 7'h00;
          nxt_q.done = 1'b1;
          nxt_q.st = XPC_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q_ff <= XPC_SEQ_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sq.done = q_ff.done;
  assign sq.rdata = q_ff.rdata;
  assign cs_n = q_ff.cs_n;
  assign we_n = q_ff.we_n;
  assign re_n = q_ff.re_n;
  assign update_n = q_ff.upd_n;
  assign reset_n = q_ff.rst_n;
  assign sel = q_ff.sel;
  assign d_out = q_ff.dout;
  assign d_oe = q_ff.doe;
endmodule : xpc_pin_seq
`default_nettype wire

/* File: design/xpc_host.sv */
// avalon-mm register front end of the crosspoint configuration host
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module xpc_host import xpc_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic xp_cs_n,
  output logic xp_we_n,
  output logic xp_readback_strobe_n,
  output logic xp_update_n,
  output logic xp_reset_n,
  output logic [4:0] xp_sel,
  output logic [6:0] xp_d_out,
  output logic [6:0] xp_d_oe,
  input wire logic [6:0] xp_d_in
);
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [4:0] sel;
    logic [6:0] word;
    logic busy;
    logic boot;
    logic req;
    xpc_op_t op;
    logic bad_sel;
    logic [XPC_ROWS-1:0] rows_set;
    logic reset_done;
    logic rb_valid;
    logic [6:0] rb_word;
  } xpc_host_state_t;

  localparam xpc_host_state_t XPC_HOST_RST = '{waitreq: 1'b1, rdata: 32'h0000_0000,
    sel: XPC_SEL_RST, word: XPC_WORD_RST, busy: 1'b0, boot: 1'b1, req: 1'b0,
    op: XPC_OP_WRITE, bad_sel: 1'b0, rows_set: '0, reset_done: 1'b0, rb_valid: 1'b0,
    rb_word: XPC_WORD_RST};

  xpc_host_state_t q_ff;
  xpc_host_state_t nxt_q;
  logic [XPC_ROWS-1:0] row_hit;

  xpc_seq_if sq ();

  // rows that a write with the current select lands in; 10001 reaches all of them
  genvar g;
  for (g = 0; g < XPC_ROWS; g++) begin : g_row
    assign row_hit[g] = (q_ff.sel == 5'(g)) || (q_ff.sel == XPC_SEL_BCAST);
  end

  always_comb begin
    logic [31:0] rd_mux;
    logic wr_ok;
    rd_mux = 32'h0000_0000;
    wr_ok = 1'b0;
    nxt_q = q_ff;
    nxt_q.req = 1'b0;

    // read mux; unmapped and unaligned offsets read as zero
    if (avs_address == XPC_OFS_SEL) begin
      rd_mux[4:0] = q_ff.sel;
    end else if (avs_address == XPC_OFS_WORD) begin
      rd_mux[6:0] = q_ff.word;
    end else if (avs_address == XPC_OFS_STAT) begin
      rd_mux[XPC_ST_BUSY] = q_ff.busy | q_ff.boot;
      rd_mux[XPC_ST_RST_DONE] = q_ff.reset_done;
      rd_mux[XPC_ST_ALL_ROWS] = &q_ff.rows_set;
      rd_mux[XPC_ST_BAD_SEL] = q_ff.bad_sel;
      rd_mux[XPC_ST_RB_VALID] = q_ff.rb_valid;
      rd_mux[XPC_ST_RB_LSB +: XPC_WORD_W] = q_ff.rb_word;
    end

    // sequencer finished: free the command slot and keep what it returned
    if (sq.done) begin
      nxt_q.busy = 1'b0;
      if (q_ff.op == XPC_OP_READ) begin
        // the word is kept until the next accepted readback replaces it
        nxt_q.rb_word = sq.rdata;
        nxt_q.rb_valid = 1'b1;
      end
      if (q_ff.op == XPC_OP_RESET) begin
        nxt_q.reset_done = 1'b1;
      end
    end

    // outputs may share buses, so the first thing after reset is a disable pulse
    if (q_ff.boot && !q_ff.busy) begin
      nxt_q.boot = 1'b0;
      nxt_q.busy = 1'b1;
      nxt_q.req = 1'b1;
      nxt_q.op = XPC_OP_RESET;
    end

    // one wait state, then the answer; the write lands on the edge that ends it
    if (q_ff.waitreq) begin
      if (avs_read || avs_write) begin
        nxt_q.waitreq = 1'b0;
        // a write leaves the last read answer standing for software
        if (avs_read) begin
          nxt_q.rdata = rd_mux;
        end
      end
    end else begin
      nxt_q.waitreq = 1'b1;
      // every writable register bit sits in byte 0; without its enable the write is dropped
      wr_ok = avs_write && avs_byteenable[0];
    end

    if (wr_ok) begin
      if (avs_address == XPC_OFS_SEL) begin
        nxt_q.sel = avs_writedata[4:0];
      end else if (avs_address == XPC_OFS_WORD) begin
        nxt_q.word = avs_writedata[6:0];
      end else if (avs_address == XPC_OFS_CMD) begin
        // a command while the sequencer is busy is dropped, not queued
        if (!q_ff.busy && !q_ff.boot) begin
          case (avs_writedata[2:0])
            XPC_CMD_WRITE: begin
              if (q_ff.sel <= XPC_SEL_BCAST) begin
                nxt_q.req = 1'b1;
                nxt_q.op = XPC_OP_WRITE;
                nxt_q.busy = 1'b1;
                nxt_q.bad_sel = 1'b0;
                nxt_q.rows_set = q_ff.rows_set | row_hit;
              end else begin
                nxt_q.bad_sel = 1'b1;
              end
            end
            XPC_CMD_UPDATE: begin
              nxt_q.req = 1'b1;
              nxt_q.op = XPC_OP_UPDATE;
              nxt_q.busy = 1'b1;
              nxt_q.bad_sel = 1'b0;
            end
            XPC_CMD_READ: begin
              // the broadcast code names no single row, so it cannot be read back
              if (q_ff.sel <= XPC_SEL_LAST) begin
                nxt_q.req = 1'b1;
                nxt_q.op = XPC_OP_READ;
                nxt_q.busy = 1'b1;
                nxt_q.bad_sel = 1'b0;
                nxt_q.rb_valid = 1'b0;
              end else begin
                nxt_q.bad_sel = 1'b1;
              end
            end
            XPC_CMD_RESET: begin
              nxt_q.req = 1'b1;
              nxt_q.op = XPC_OP_RESET;
              nxt_q.busy = 1'b1;
              nxt_q.bad_sel = 1'b0;
            end
            default: begin
              // unknown codes start nothing and leave every flag alone
              nxt_q.bad_sel = q_ff.bad_sel;
            end
          endcase
        end
      end
    end
  end

  // the whole state sits in one register, so every bus output is a flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      q_ff <= XPC_HOST_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sq.req = q_ff.req;
  assign sq.op = q_ff.op;
  assign sq.sel = q_ff.sel;
  assign sq.word = q_ff.word;
  assign avs_readdata = q_ff.rdata;
  assign avs_waitrequest = q_ff.waitreq;

  // the sequencer keeps chip select high between operations, leaving the
  // device's latches and routing alone while idle
  xpc_pin_seq u_seq (
    .mclk(mclk),
    .srst(srst),
    .sq(sq.seq),
    .cs_n(xp_cs_n),
    .we_n(xp_we_n),
    .re_n(xp_readback_strobe_n),
    .update_n(xp_update_n),
    .reset_n(xp_reset_n),
    .sel(xp_sel),
    .d_out(xp_d_out),
    .d_oe(xp_d_oe),
    .d_in(xp_d_in)
  );
endmodule : xpc_host
`default_nettype wire

/* File: verif/xpc_host_chk.sv */
// concurrent checks on the bus and device pins of the crosspoint host
`timescale 1ns/1ps
`default_nettype none
module xpc_host_chk import xpc_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic xp_cs_n,
  input wire logic xp_we_n,
  input wire logic xp_readback_strobe_n,
  input wire logic xp_update_n,
  input wire logic xp_reset_n,
  input wire logic [4:0] xp_sel,
  input wire logic [6:0] xp_d_out,
  input wire logic [6:0] xp_d_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wr_pulse_a: assert property ($fell(xp_we_n) |=> xp_we_n)
    else $error("write strobe low too long");
  wr_frame_a: assert property (!xp_we_n |-> !xp_cs_n && xp_d_oe == 7'h7f &&
    $stable(xp_d_out) && $stable(xp_sel)) else $error("write strobe outside a clean frame");
  rb_quiet_a: assert property (!xp_readback_strobe_n |-> !xp_cs_n && xp_d_oe == 7'h00)
    else $error("host drives data during readback");
  rb_sel_a: assert property (!xp_readback_strobe_n |-> xp_sel <= XPC_SEL_LAST)
    else $error("readback of a missing row");
  upd_frame_a: assert property (!xp_update_n |-> !xp_cs_n && xp_we_n &&
    xp_readback_strobe_n) else $error("transfer strobe outside a clean frame");
  wr_sel_a: assert property (!xp_we_n |-> xp_sel <= XPC_SEL_BCAST)
    else $error("write to an invalid select");
  rst_pulse_a: assert property ($fell(xp_reset_n) |-> xp_cs_n ##1 xp_reset_n)
    else $error("reset pulse malformed");
  boot_rst_a: assert property ($fell(srst) |-> ##[1:5] !xp_reset_n)
    else $error("no reset pulse after power-up");
  bus_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  bus_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  cover property (!xp_we_n && xp_sel == XPC_SEL_BCAST);
  cover property (!xp_update_n);
  cover property (!xp_readback_strobe_n);
  cover property ($fell(xp_reset_n));
endmodule : xpc_host_chk
bind xpc_host xpc_host_chk u_chk (.mclk(mclk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .xp_cs_n(xp_cs_n),
  .xp_we_n(xp_we_n), .xp_readback_strobe_n(xp_readback_strobe_n),
  .xp_update_n(xp_update_n), .xp_reset_n(xp_reset_n), .xp_sel(xp_sel),
  .xp_d_out(xp_d_out), .xp_d_oe(xp_d_oe));
`default_nettype wire

/* File: verif/xpc_dev_model.sv */
// behavioural model of the crosspoint configuration port
`timescale 1ns/1ps
`default_nettype none
module xpc_dev_model import xpc_pkg::*; (
  input wire logic mclk,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic update_n,
  input wire logic reset_n,
  input wire logic [4:0] sel,
  input wire logic [6:0] d_out,
  input wire logic [6:0] d_oe,
  output logic [6:0] d_in
);
  logic [6:0] pending_connection_row [XPC_ROWS];
  logic [6:0] active_connection_row [XPC_ROWS];
  logic [6:0] last_ff = 7'h00;
  logic clash_ff = 1'b0;
  logic rb_on;
  // power-up contents are undefined; a fixed odd pattern stands in
  initial begin
    for (int i = 0; i < XPC_ROWS; i++) begin
      pending_connection_row[i] = 7'h2a;
      active_connection_row[i] = 7'h55;
    end
  end
  assign rb_on = !cs_n && !re_n && sel <= XPC_SEL_LAST;
  // an undriven line has no pull, so it shows a value that toggles each cycle
  assign d_in = (d_oe & d_out) | (~d_oe & (rb_on ? active_connection_row[sel] : ~last_ff));
  always @(posedge mclk) begin
    last_ff <= d_in;
    if (rb_on && d_oe != 7'h00) clash_ff <= 1'b1;
  end
  // mid-cycle sampling stands in for latches open while a strobe is low
  always @(negedge mclk) begin
    for (int i = 0; i < XPC_ROWS; i++) begin
      if (!cs_n && !we_n && (sel == 5'(i) || sel == XPC_SEL_BCAST))
        pending_connection_row[i] <= d_in;
      if (!cs_n && !update_n) active_connection_row[i] <= pending_connection_row[i];
      if (!reset_n) active_connection_row[i][XPC_EN_BIT] <= 1'b0;
    end
  end
endmodule : xpc_dev_model
`default_nettype wire

/* File: verif/xpc_host_tb.sv */
// self-checking bench of the crosspoint host against the port model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module xpc_host_tb import xpc_pkg::*; ;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] avs_readdata, st;
  logic avs_waitrequest, cs_n, we_n, rb_n, upd_n, rst_n;
  logic [4:0] sel;
  logic [6:0] d_out, d_oe, d_in;
  int fails = 0;
  int compares = 0;
  always #50 mclk = ~mclk;
  xpc_host dut (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xp_cs_n(cs_n),
    .xp_we_n(we_n), .xp_readback_strobe_n(rb_n), .xp_update_n(upd_n), .xp_reset_n(rst_n),
    .xp_sel(sel), .xp_d_out(d_out), .xp_d_oe(d_oe), .xp_d_in(d_in));
  xpc_dev_model m (.mclk(mclk), .cs_n(cs_n), .we_n(we_n), .re_n(rb_n), .update_n(upd_n),
    .reset_n(rst_n), .sel(sel), .d_out(d_out), .d_oe(d_oe), .d_in(d_in));
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim();
    end
    @(posedge mclk);
  endtask : av
  task automatic op(input logic [4:0] s, input logic [6:0] w, input logic [2:0] c);
    logic [31:0] q;
    int n = 0;
    av(1'b1, XPC_OFS_SEL, {27'h0, s}, q);
    av(1'b1, XPC_OFS_WORD, {25'h0, w}, q);
    av(1'b1, XPC_OFS_CMD, {29'h0, c}, q);
    do begin
      av(1'b0, XPC_OFS_STAT, 32'h0, st);
      n++;
    end while (st[XPC_ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      end_sim();
    end
  endtask : op
  task automatic t_boot;
    int n = 0;
    do begin
      av(1'b0, XPC_OFS_STAT, 32'h0, st);
      n++;
    end while ((st[XPC_ST_RST_DONE] !== 1'b1 || st[XPC_ST_BUSY] !== 1'b0) && n < 20);
    if (n >= 20) begin
      fails++;
      end_sim();
    end
    `CHK("boot", 1'b1, st[XPC_ST_RST_DONE])
    for (int i = 0; i < XPC_ROWS; i++) begin
      `CHK("active", 7'h15, m.active_connection_row[i])
      `CHK("pending", 7'h2a, m.pending_connection_row[i])
    end
  endtask : t_boot
  task automatic t_update;
    op(XPC_SEL_BCAST, 7'h47, XPC_CMD_WRITE);
    op(XPC_SEL_LAST, 7'h60, XPC_CMD_WRITE);
    `CHK("all rows", 1'b1, st[XPC_ST_ALL_ROWS])
    for (int i = 0; i < XPC_ROWS; i++) `CHK("held", 7'h15, m.active_connection_row[i])
    op(5'h00, 7'h00, XPC_CMD_UPDATE);
    for (int i = 0; i < XPC_ROWS; i++)
      `CHK("moved", (i == 16) ? 7'h60 : 7'h47, m.active_connection_row[i])
    op(XPC_SEL_LAST, 7'h00, XPC_CMD_READ);
    `CHK("readback", 7'h60, st[XPC_ST_RB_LSB +: 7])
    op(5'h03, 7'h00, XPC_CMD_READ);
    `CHK("readback", 7'h47, st[XPC_ST_RB_LSB +: 7])
  endtask : t_update
  task automatic t_disable;
    logic [6:0] ex;
    op(5'h05, 7'h05, XPC_CMD_WRITE);
    op(5'h00, 7'h00, XPC_CMD_UPDATE);
    `CHK("disabled", 7'h05, m.active_connection_row[5])
    op(5'h00, 7'h00, XPC_CMD_RESET);
    for (int i = 0; i < XPC_ROWS; i++) begin
      ex = (i == 16) ? 7'h20 : (i == 5) ? 7'h05 : 7'h07;
      `CHK("cleared", ex, m.active_connection_row[i])
    end
    `CHK("kept", 7'h60, m.pending_connection_row[16])
  endtask : t_disable
  task automatic t_bad;
    op(5'h12, 7'h7f, XPC_CMD_WRITE);
    `CHK("bad sel", 1'b1, st[XPC_ST_BAD_SEL])
    `CHK("kept", 7'h47, m.pending_connection_row[0])
    op(XPC_SEL_BCAST, 7'h00, XPC_CMD_READ);
    `CHK("bad sel", 1'b1, st[XPC_ST_BAD_SEL])
    op(5'h00, 7'h00, XPC_CMD_READ);
    `CHK("bad sel", 1'b0, st[XPC_ST_BAD_SEL])
    `CHK("readback", 7'h07, st[XPC_ST_RB_LSB +: 7])
  endtask : t_bad
  task automatic t_regs;
    logic [31:0] q;
    av(1'b0, 4'h2, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    av(1'b1, XPC_OFS_SEL, 32'hffff_ffff, q);
    av(1'b0, XPC_OFS_SEL, 32'h0, q);
    `CHK("sel reg", 32'h1f, q)
    av(1'b0, XPC_OFS_CMD, 32'h0, q);
    `CHK("cmd reg", 32'h0, q)
    // a write without byte 0 enabled must leave the select alone
    be <= 4'he;
    av(1'b1, XPC_OFS_SEL, 32'h0000_0003, q);
    be <= 4'hf;
    av(1'b0, XPC_OFS_SEL, 32'h0, q);
    `CHK("masked write", 32'h1f, q)
    av(1'b1, XPC_OFS_CMD, 32'h0000_0005, q);
    av(1'b0, XPC_OFS_STAT, 32'h0, q);
    `CHK("unknown cmd", 2'h0, {q[XPC_ST_BUSY], q[XPC_ST_BAD_SEL]})
  endtask : t_regs
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_boot();
    t_update();
    t_disable();
    t_bad();
    t_regs();
    `CHK("clash", 1'b0, m.clash_ff)
    end_sim();
  end
endmodule : xpc_host_tb
`default_nettype wire
